/* File: hdl/wrt_pkg.sv */
package wrt_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_COUNT = 8'h00;
  localparam logic [7:0] ADDR_TCTL = 8'h04;
  localparam logic [7:0] ADDR_RCSR = 8'h08;
  localparam logic [7:0] ADDR_ISTAT = 8'h0C;
  localparam logic [7:0] ADDR_IMASK = 8'h10;

  // ----------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------
  localparam int TCTL_WD_SEL = 6;
  localparam int TCTL_EN = 5;
  localparam int TCTL_CKS_HI = 2;
  localparam int TCTL_CKS_LO = 0;
  localparam logic [7:0] TCTL_RESET = 8'h00;
  localparam logic [7:0] TCTL_WMASK = 8'h67;
  localparam int RCSR_OVF = 7;
  localparam int RCSR_RSTE = 6;
  localparam int RCSR_RSTS = 5;
  localparam logic [7:0] RCSR_RESET = 8'h1F;
  localparam logic [7:0] RCSR_FIXED = 8'h1F;
  localparam int IRQ_W = 2;
  localparam int IRQ_WDOG = 0;
  localparam int IRQ_INTV = 1;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Count clock prescaler: select code to divide-by-2^shift
  // ----------------------------------------------------------------
  localparam int PRESC_W = 17;
  localparam logic [PRESC_W-1:0] PRESC_RESET = 17'h00000;
  localparam logic [PRESC_W-1:0] PRESC_STEP = 17'h00001;
  localparam logic [4:0] CKS_SHIFT [0:7] = '{5'h01, 5'h06, 5'h07, 5'h09,
                                            5'h0B, 5'h0D, 5'h0F, 5'h11};

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int RST_PULSE_NS = 1000;
  localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] RST_CNT_LOAD = 8'(RST_PULSE_CYC);
  localparam logic [7:0] RST_CNT_ZERO = 8'h00;
  localparam logic [7:0] RST_CNT_STEP = 8'h01;

endpackage

/* File: hdl/wrt_cnt_if.sv */
`timescale 1ns/10ps
interface wrt_cnt_if;
  logic enable;
  logic [2:0] clk_sel;
  logic tick;
  logic load;
  logic [7:0] load_value;
  logic [7:0] count;
  logic overflow;
  modport ctrl(output enable, output clk_sel, output load, output load_value,
               input count, input overflow);
  modport div(input enable, input clk_sel, output tick);
  modport cnt(input enable, input tick, input load, input load_value,
              output count, output overflow);
endinterface

/* File: hdl/wrt_tick_div.sv */
`timescale 1ns/10ps
module wrt_tick_div (
  input wire logic aclk,
  input wire logic aresetn,
  wrt_cnt_if.div bus
);

  logic [wrt_pkg::PRESC_W-1:0] presc;
  logic [wrt_pkg::PRESC_W-1:0] next_presc;
  logic [wrt_pkg::PRESC_W-1:0] mask;
  logic [4:0] shift;

  // ----------------------------------------------------------------
  // Divide-by-2^shift enable pulse
  // ----------------------------------------------------------------
  assign shift = wrt_pkg::CKS_SHIFT[bus.clk_sel];

  genvar i;
  for (i = 0; i < wrt_pkg::PRESC_W; i++) begin : g_mask
    assign mask[i] = (5'(i) < shift);
  end

  // Select code 0 gives a tick every second clock
  assign bus.tick = bus.enable && ((presc & mask) == mask);

  always_comb begin
    next_presc = wrt_pkg::PRESC_RESET;
    if (bus.enable) begin
      next_presc = presc + wrt_pkg::PRESC_STEP;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc <= wrt_pkg::PRESC_RESET;
    end else begin
      presc <= next_presc;
    end
  end

endmodule

/* File: hdl/wrt_counter.sv */
`timescale 1ns/10ps
module wrt_counter (
  input wire logic aclk,
  input wire logic aresetn,
  wrt_cnt_if.cnt bus
);

  logic [7:0] count;
  logic [7:0] next_count;

  assign bus.count = count;
  // Wrap from the maximum on a tick, unless software loads this cycle
  assign bus.overflow = bus.enable && !bus.load && bus.tick
                        && (count == wrt_pkg::COUNT_MAX);

  // ----------------------------------------------------------------
  // Eight-bit up-counter
  // ----------------------------------------------------------------
  always_comb begin
    next_count = count;
    if (!bus.enable) begin
      next_count = wrt_pkg::COUNT_RESET;
    end else if (bus.load) begin
      next_count = bus.load_value;
    end else if (bus.tick) begin
      next_count = count + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= wrt_pkg::COUNT_RESET;
    end else begin
      count <= next_count;
    end
  end

endmodule

/* File: hdl/wrt_top.sv */
// What this block does
// - The watchdog count is an eight-bit up-counter, readable and writable.
// - While the timer enable bit is clear, the count is held at zero.
// - Timer control register selects the count clock and the operating mode.
// - Reset control register enables overflow reset and picks its type.
// - External reset sets the reset control register to 0x1F.
// - The watchdog's own internal reset leaves the reset control register unchanged.
// - Watchdog mode only when mode select and timer enable are both one.
// - Half the peripheral clock is a selectable count clock, one count per tick.
// - Overflow on wrap past maximum: 256 minus loaded value ticks.
// - Overflow in watchdog mode with reset enabled asserts internal reset.
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
module wrt_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  output logic int_reset_n,
  output logic int_reset_type
);

  typedef enum logic [1:0] {
    WRT_WR_IDLE = 2'b01,
    WRT_WR_RESP = 2'b10
  } wrt_wr_state_t;

  typedef enum logic [1:0] {
    WRT_RD_IDLE = 2'b01,
    WRT_RD_RESP = 2'b10
  } wrt_rd_state_t;

  function automatic logic wrt_mapped(input logic [7:0] addr);
    wrt_mapped = (addr == wrt_pkg::ADDR_COUNT) || (addr == wrt_pkg::ADDR_TCTL)
              || (addr == wrt_pkg::ADDR_RCSR) || (addr == wrt_pkg::ADDR_ISTAT)
              || (addr == wrt_pkg::ADDR_IMASK);
  endfunction

  wrt_cnt_if cnt_bus();

  // ----------------------------------------------------------------
  // Write channel state
  // ----------------------------------------------------------------
  wrt_wr_state_t wr_state;
  wrt_wr_state_t next_wr_state;
  logic aw_held;
  logic next_aw_held;
  logic w_held;
  logic next_w_held;
  logic [7:0] awaddr_q;
  logic [7:0] next_awaddr_q;
  logic [31:0] wdata_q;
  logic [31:0] next_wdata_q;
  logic wstrb0_q;
  logic next_wstrb0_q;
  logic [1:0] bresp;
  logic [1:0] next_bresp;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic wr_strb0;
  logic wr_fire;
  logic reg_wr;

  assign s_axi_awready = (wr_state == WRT_WR_IDLE) && !aw_held;
  assign s_axi_wready = (wr_state == WRT_WR_IDLE) && !w_held;
  assign s_axi_bvalid = (wr_state == WRT_WR_RESP);
  assign s_axi_bresp = bresp;
  assign wr_addr = aw_held ? awaddr_q : s_axi_awaddr;
  assign wr_data = w_held ? wdata_q : s_axi_wdata;
  assign wr_strb0 = w_held ? wstrb0_q : s_axi_wstrb[0];
  assign wr_fire = (wr_state == WRT_WR_IDLE) && (aw_held || s_axi_awvalid)
                   && (w_held || s_axi_wvalid);
  assign reg_wr = wr_fire && wrt_mapped(wr_addr) && wr_strb0;

  always_comb begin
    next_wr_state = wr_state;
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_awaddr_q = awaddr_q;
    next_wdata_q = wdata_q;
    next_wstrb0_q = wstrb0_q;
    next_bresp = bresp;
    unique case (wr_state)
      WRT_WR_IDLE: begin
        if (wr_fire) begin
          next_wr_state = WRT_WR_RESP;
          next_aw_held = 1'b0;
          next_w_held = 1'b0;
          next_bresp = wrt_mapped(wr_addr) ? wrt_pkg::RESP_OKAY : wrt_pkg::RESP_SLVERR;
        end else begin
          if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_awaddr_q = s_axi_awaddr;
          end
          if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_wdata_q = s_axi_wdata;
            next_wstrb0_q = s_axi_wstrb[0];
          end
        end
      end
      WRT_WR_RESP: begin
        if (s_axi_bready) begin
          next_wr_state = WRT_WR_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= WRT_WR_IDLE;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb0_q <= 1'b0;
      bresp <= wrt_pkg::RESP_OKAY;
    end else begin
      wr_state <= next_wr_state;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      awaddr_q <= next_awaddr_q;
      wdata_q <= next_wdata_q;
      wstrb0_q <= next_wstrb0_q;
      bresp <= next_bresp;
    end
  end

  // ----------------------------------------------------------------
  // Control and status registers
  // ----------------------------------------------------------------
  logic [7:0] tctl;
  logic [7:0] next_tctl;
  logic rste;
  logic next_rste;
  logic rsts;
  logic next_rsts;
  logic wovf;
  logic next_wovf;
  logic [wrt_pkg::IRQ_W-1:0] istat;
  logic [wrt_pkg::IRQ_W-1:0] next_istat;
  logic [wrt_pkg::IRQ_W-1:0] imask;
  logic [wrt_pkg::IRQ_W-1:0] next_imask;
  logic [7:0] rst_cnt;
  logic [7:0] next_rst_cnt;
  logic rst_type;
  logic next_rst_type;
  logic next_int_reset_n;
  logic wd_mode;
  logic [7:0] rcsr_view;

  assign wd_mode = tctl[wrt_pkg::TCTL_WD_SEL] && tctl[wrt_pkg::TCTL_EN];
  assign rcsr_view = {wovf, rste, rsts, wrt_pkg::RCSR_FIXED[4:0]};

  assign cnt_bus.enable = tctl[wrt_pkg::TCTL_EN];
  assign cnt_bus.clk_sel = tctl[wrt_pkg::TCTL_CKS_HI:wrt_pkg::TCTL_CKS_LO];
  assign cnt_bus.load = reg_wr && (wr_addr == wrt_pkg::ADDR_COUNT);
  assign cnt_bus.load_value = wr_data[7:0];

  assign irq = |(istat & imask);
  assign int_reset_type = rst_type;

  always_comb begin
    next_tctl = tctl;
    next_rste = rste;
    next_rsts = rsts;
    next_wovf = wovf;
    next_istat = istat;
    next_imask = imask;
    next_rst_type = rst_type;
    next_rst_cnt = rst_cnt;
    if (rst_cnt != wrt_pkg::RST_CNT_ZERO) begin
      next_rst_cnt = rst_cnt - wrt_pkg::RST_CNT_STEP;
    end
    if (reg_wr) begin
      case (wr_addr)
        wrt_pkg::ADDR_TCTL: begin
          next_tctl = wr_data[7:0] & wrt_pkg::TCTL_WMASK;
        end
        wrt_pkg::ADDR_RCSR: begin
          next_rste = wr_data[wrt_pkg::RCSR_RSTE];
          next_rsts = wr_data[wrt_pkg::RCSR_RSTS];
          if (!wr_data[wrt_pkg::RCSR_OVF]) begin
            next_wovf = 1'b0;
          end
        end
        wrt_pkg::ADDR_ISTAT: begin
          next_istat = istat & ~wr_data[wrt_pkg::IRQ_W-1:0];
        end
        wrt_pkg::ADDR_IMASK: begin
          next_imask = wr_data[wrt_pkg::IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
    // Events come after software clears so that a set wins
    if (cnt_bus.overflow) begin
      if (wd_mode) begin
        next_wovf = 1'b1;
        next_istat[wrt_pkg::IRQ_WDOG] = 1'b1;
        if (rste) begin
          // Internal reset clears timer state; reset control is left alone
          next_rst_cnt = wrt_pkg::RST_CNT_LOAD;
          next_rst_type = rsts;
          next_tctl = wrt_pkg::TCTL_RESET;
        end
      end else begin
        next_istat[wrt_pkg::IRQ_INTV] = 1'b1;
      end
    end
    next_int_reset_n = (next_rst_cnt == wrt_pkg::RST_CNT_ZERO);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tctl <= wrt_pkg::TCTL_RESET;
      rste <= wrt_pkg::RCSR_RESET[wrt_pkg::RCSR_RSTE];
      rsts <= wrt_pkg::RCSR_RESET[wrt_pkg::RCSR_RSTS];
      wovf <= wrt_pkg::RCSR_RESET[wrt_pkg::RCSR_OVF];
      istat <= wrt_pkg::IRQ_RESET;
      imask <= wrt_pkg::IRQ_RESET;
      rst_cnt <= wrt_pkg::RST_CNT_ZERO;
      rst_type <= 1'b0;
      int_reset_n <= 1'b1;
    end else begin
      tctl <= next_tctl;
      rste <= next_rste;
      rsts <= next_rsts;
      wovf <= next_wovf;
      istat <= next_istat;
      imask <= next_imask;
      rst_cnt <= next_rst_cnt;
      rst_type <= next_rst_type;
      int_reset_n <= next_int_reset_n;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  wrt_rd_state_t rd_state;
  wrt_rd_state_t next_rd_state;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [1:0] rresp;
  logic [1:0] next_rresp;

  assign s_axi_arready = (rd_state == WRT_RD_IDLE);
  assign s_axi_rvalid = (rd_state == WRT_RD_RESP);
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  always_comb begin
    next_rd_state = rd_state;
    next_rdata = rdata;
    next_rresp = rresp;
    unique case (rd_state)
      WRT_RD_IDLE: begin
        if (s_axi_arvalid) begin
          next_rd_state = WRT_RD_RESP;
          next_rresp = wrt_pkg::RESP_OKAY;
          next_rdata = 32'h00000000;
          case (s_axi_araddr)
            wrt_pkg::ADDR_COUNT: next_rdata[7:0] = cnt_bus.count;
            wrt_pkg::ADDR_TCTL: next_rdata[7:0] = tctl;
            wrt_pkg::ADDR_RCSR: next_rdata[7:0] = rcsr_view;
            wrt_pkg::ADDR_ISTAT: next_rdata[wrt_pkg::IRQ_W-1:0] = istat;
            wrt_pkg::ADDR_IMASK: next_rdata[wrt_pkg::IRQ_W-1:0] = imask;
            default: next_rresp = wrt_pkg::RESP_SLVERR;
          endcase
        end
      end
      WRT_RD_RESP: begin
        if (s_axi_rready) begin
          next_rd_state = WRT_RD_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state <= WRT_RD_IDLE;
      rdata <= 32'h00000000;
      rresp <= wrt_pkg::RESP_OKAY;
    end else begin
      rd_state <= next_rd_state;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // ----------------------------------------------------------------
  // Count clock divider and counter
  // ----------------------------------------------------------------
  wrt_tick_div u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .bus(cnt_bus.div)
  );

  wrt_counter u_cnt (
    .aclk(aclk),
    .aresetn(aresetn),
    .bus(cnt_bus.cnt)
  );

endmodule

/* File: verification/wrt_checker.sv */
`timescale 1ns/10ps
module wrt_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq,
  input wire logic int_reset_n,
  input wire logic int_reset_type
);
  // ----------------------------------------------------------------
  // Length of the internal reset pulse
  // ----------------------------------------------------------------
  logic [7:0] low_cnt;
  logic [7:0] next_low_cnt;

  always_comb begin
    next_low_cnt = int_reset_n ? 8'h00 : low_cnt + 8'h01;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_cnt <= 8'h00;
    end else begin
      low_cnt <= next_low_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  rst_idle_a: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && int_reset_n)
    else $error("outputs not idle after reset");
  pulse_len_a: assert property ($rose(int_reset_n) |-> low_cnt == 8'h32)
    else $error("internal reset pulse length wrong");
  type_hold_a: assert property (!int_reset_n && !$fell(int_reset_n) |-> $stable(int_reset_type))
    else $error("reset type changed during pulse");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid) else $error("write response late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  rcsr_fixed_a: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == wrt_pkg::ADDR_RCSR |=> s_axi_rdata[4:0] == 5'h1F) else $error("fixed bits lost");
  rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  rd_slverr_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h10
    |=> s_axi_rresp == wrt_pkg::RESP_SLVERR) else $error("unmapped read not refused");

  cov_reset_c: cover property ($fell(int_reset_n));
  cov_irq_c: cover property ($rose(irq));
  cov_err_c: cover property (s_axi_rvalid && s_axi_rresp == wrt_pkg::RESP_SLVERR);
endmodule

bind wrt_top wrt_checker wrt_checker_i (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq),
  .int_reset_n(int_reset_n), .int_reset_type(int_reset_type));

/* File: verification/wrt_top_tb.sv */
`timescale 1ns/10ps
module wrt_top_tb;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq, int_reset_n, int_reset_type;
  logic [7:0] awaddr, araddr;
  logic [3:0] wstrb;
  logic [31:0] wdata, rdata, rdata_q;
  logic [1:0] bresp, rresp, bresp_q, rresp_q;
  int err_count, comparisons, cyc, lowc;

  wrt_top wrt_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq),
    .int_reset_n(int_reset_n), .int_reset_type(int_reset_type));

  // ----------------------------------------------------------------
  // Clock, hang limit and reset pulse monitor
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end

  always @(negedge aclk) begin
    if (int_reset_n !== 1'b1) lowc++;
  end

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic results;
    if (err_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, done;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      done = bvalid;
      bresp_q = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (done) bready <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] a);
    logic ta, done;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(negedge aclk);
      ta = arvalid && arready;
      done = rvalid;
      rdata_q = rdata;
      rresp_q = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (done) rready <= 1'b0;
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    rd(a);
    chk(nm, rdata_q, exp);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rchk(wrt_pkg::ADDR_COUNT, 32'h0, "count");
    rchk(wrt_pkg::ADDR_TCTL, 32'h0, "tctl");
    rchk(wrt_pkg::ADDR_RCSR, 32'h1F, "rcsr");
    rd(8'h40);
    chk("unmapped rd", 32'(rresp_q), 32'(wrt_pkg::RESP_SLVERR));
    wr(8'h44, 32'h0);
    chk("unmapped wr", 32'(bresp_q), 32'(wrt_pkg::RESP_SLVERR));
  endtask

  task automatic t_rw;
    wr(wrt_pkg::ADDR_TCTL, 32'h9F);
    rchk(wrt_pkg::ADDR_TCTL, 32'h07, "tctl bits");
    wr(wrt_pkg::ADDR_COUNT, 32'h55);
    rchk(wrt_pkg::ADDR_COUNT, 32'h0, "count off");
    wr(wrt_pkg::ADDR_TCTL, 32'h27);
    wr(wrt_pkg::ADDR_COUNT, 32'hA5);
    rchk(wrt_pkg::ADDR_COUNT, 32'hA5, "count load");
    wstrb <= 4'hE;
    wr(wrt_pkg::ADDR_COUNT, 32'h33);
    chk("strb resp", 32'(bresp_q), 32'(wrt_pkg::RESP_OKAY));
    rchk(wrt_pkg::ADDR_COUNT, 32'hA5, "strb off");
    wstrb <= 4'hF;
    wr(wrt_pkg::ADDR_TCTL, 32'h07);
    rchk(wrt_pkg::ADDR_COUNT, 32'h0, "count clear");
    // Select code 1 divides by 64: one tick after 64 cycles
    wr(wrt_pkg::ADDR_TCTL, 32'h21);
    repeat (100) @(negedge aclk);
    rchk(wrt_pkg::ADDR_COUNT, 32'h1, "count div64");
    wr(wrt_pkg::ADDR_TCTL, 32'h0);
  endtask

  task automatic t_interval;
    wr(wrt_pkg::ADDR_RCSR, 32'h40);
    wr(wrt_pkg::ADDR_IMASK, 32'h2);
    wr(wrt_pkg::ADDR_TCTL, 32'h20);
    wr(wrt_pkg::ADDR_COUNT, 32'hF0);
    repeat (40) @(negedge aclk);
    chk("irq interval", 32'(irq), 32'h1);
    chk("no reset", lowc, 0);
    rchk(wrt_pkg::ADDR_ISTAT, 32'h2, "status");
    wr(wrt_pkg::ADDR_IMASK, 32'h0);
    chk("irq masked", 32'(irq), 32'h0);
    wr(wrt_pkg::ADDR_TCTL, 32'h0);
    wr(wrt_pkg::ADDR_ISTAT, 32'h2);
    rchk(wrt_pkg::ADDR_ISTAT, 32'h0, "status clr");
    rchk(wrt_pkg::ADDR_RCSR, 32'h5F, "rcsr intv");
  endtask

  task automatic t_watchdog;
    int n;
    wr(wrt_pkg::ADDR_TCTL, 32'h60);
    repeat (5) begin
      wr(wrt_pkg::ADDR_COUNT, 32'h10);
      repeat (300) @(negedge aclk);
    end
    chk("reload", lowc, 0);
    wr(wrt_pkg::ADDR_RCSR, 32'h60);
    wr(wrt_pkg::ADDR_IMASK, 32'h1);
    wr(wrt_pkg::ADDR_COUNT, 32'hF0);
    n = 0;
    while (int_reset_n === 1'b1 && n < 100) begin
      @(negedge aclk);
      n++;
    end
    chk("ovf time", 32'(n >= 28 && n <= 34), 32'h1);
    chk("reset type", 32'(int_reset_type), 32'h1);
    n = 0;
    while (int_reset_n !== 1'b1 && n < 100) begin
      @(negedge aclk);
      n++;
    end
    chk("pulse", n, 50);
    rchk(wrt_pkg::ADDR_RCSR, 32'hFF, "rcsr kept");
    rchk(wrt_pkg::ADDR_TCTL, 32'h0, "tctl clr");
    rchk(wrt_pkg::ADDR_ISTAT, 32'h1, "status wd");
    chk("irq wd", 32'(irq), 32'h1);
    wr(wrt_pkg::ADDR_ISTAT, 32'h1);
    wr(wrt_pkg::ADDR_RCSR, 32'h0);
    rchk(wrt_pkg::ADDR_RCSR, 32'h1F, "ovf clr");
    wr(wrt_pkg::ADDR_TCTL, 32'h60);
    wr(wrt_pkg::ADDR_COUNT, 32'hF0);
    repeat (60) @(negedge aclk);
    chk("rste off", lowc, 50);
    rchk(wrt_pkg::ADDR_RCSR, 32'h9F, "ovf only");
  endtask

  task automatic t_ext;
    wr(wrt_pkg::ADDR_RCSR, 32'h60);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(wrt_pkg::ADDR_RCSR, 32'h1F, "rcsr ext");
    rchk(wrt_pkg::ADDR_TCTL, 32'h0, "tctl ext");
  endtask

  initial begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_rw();
    t_interval();
    t_watchdog();
    t_ext();
    results();
  end
endmodule
